/* File: ouc_pkg.sv */
// Package of constants and types for the operand addressing unit.
// Functional notes
// - Byte-count copy runs while low count nonzero.
// - Word-count copy uses 16-bit count register.
// - Words of two bytes, operation_field top nibble.
// - Register fields are three or four bits.
// - Extensions 8/16/32 bits, 24-bit zero-padded.
// - Branch condition taken from condition field.
// - Bit ops except test read, modify one bit, write back.
// - Write-only direction register reads as all ones.
// - Bit clear reads the byte before clearing the flag.
// - Eight modes; ALU only register or immediate.
// - Transfers reject PC-relative and memory indirect.
// - Bit ops: direct, indirect or short absolute.
// - Register direct picks byte, word or long.
// - Indirect address is pointer's low 24 bits.
// - Displacement added, 16-bit sign-extended first.
// - Post-increment adds access size to pointer.
// - Short absolute fills upper 16 bits with ones.
package ouc_pkg;
  typedef logic [23:0] ouc_addr_t;
  typedef logic [31:0] ouc_word_t;
  // Operation field codes in the top nibble of the instruction word.
  localparam logic [3:0] OP_NOP    = 4'h0;
  localparam logic [3:0] OP_EA     = 4'h1;
  localparam logic [3:0] OP_ALU    = 4'h2;
  localparam logic [3:0] OP_XFER   = 4'h3;
  localparam logic [3:0] OP_REG    = 4'h4;
  localparam logic [3:0] OP_BCC    = 4'h5;
  localparam logic [3:0] OP_BIT_RD = 4'h6;
  localparam logic [3:0] OP_BIT_RI = 4'h7;
  localparam logic [3:0] OP_BIT_AB = 4'h8;
  localparam logic [3:0] OP_COPY   = 4'h9;
  // Addressing modes.
  localparam logic [2:0] M_REG  = 3'h0;
  localparam logic [2:0] M_IND  = 3'h1;
  localparam logic [2:0] M_DISP = 3'h2;
  localparam logic [2:0] M_INC  = 3'h3;
  localparam logic [2:0] M_ABS  = 3'h4;
  localparam logic [2:0] M_IMM  = 3'h5;
  localparam logic [2:0] M_PCR  = 3'h6;
  localparam logic [2:0] M_MIND = 3'h7;
  // Bit operation kinds.
  localparam logic [2:0] B_SET = 3'h0;
  localparam logic [2:0] B_CLR = 3'h1;
  localparam logic [2:0] B_NOT = 3'h2;
  localparam logic [2:0] B_ST  = 3'h3;
  localparam logic [2:0] B_IST = 3'h4;
  localparam logic [2:0] B_TST = 3'h5;
  // Extension sizes.
  localparam logic [1:0] X_8  = 2'h0;
  localparam logic [1:0] X_16 = 2'h1;
  localparam logic [1:0] X_24 = 2'h2;
  localparam logic [1:0] X_32 = 2'h3;
  // Fixed register roles of the block copy.
  localparam logic [2:0] CNT_REG = 3'h4;
  localparam logic [2:0] SRC_REG = 3'h5;
  localparam logic [2:0] DST_REG = 3'h6;
  localparam ouc_addr_t  WO_DIR_ADDR = 24'hffff20;
  localparam logic [7:0] WO_READ     = 8'hff;
  localparam logic [15:0] SHORT_HI   = 16'hffff;
  localparam ouc_word_t  GR_RST      = 32'h0000_0000;
  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_BRD  = 6'h02,
    S_BWR  = 6'h04,
    S_CCHK = 6'h08,
    S_CRD  = 6'h10,
    S_CWR  = 6'h20
  } ouc_st_t;
endpackage

/* File: ouc_unit.sv */
// Decode, address generation, bit read-modify-write and block copy.
`timescale 1ns/100ps
module ouc_unit (
  input  wire logic             core_clk_i,
  input  wire logic             reset_n_i,
  input  wire logic             instr_valid_i,
  input  wire logic [15:0]      instr_word_i,
  input  wire ouc_pkg::ouc_word_t ext_i,
  input  wire logic [1:0]       ext_size_i,
  input  wire logic [3:0]       flags_i,
  input  wire logic             reg_wr_i,
  input  wire logic [2:0]       reg_idx_i,
  input  wire ouc_pkg::ouc_word_t reg_wdata_i,
  input  wire logic [7:0]       mem_rdata_i,
  input  wire logic             mem_ack_i,
  output logic                  ready_o,
  output logic                  done_o,
  output logic                  illegal_o,
  output logic                  taken_o,
  output ouc_pkg::ouc_word_t    ea_o,
  output ouc_pkg::ouc_word_t    operand_o,
  output logic                  mem_req_o,
  output logic                  mem_we_o,
  output ouc_pkg::ouc_addr_t    mem_addr_o,
  output logic [7:0]            mem_wdata_o
);
  import ouc_pkg::*;

  typedef struct packed {
    ouc_st_t             st;
    logic [7:0][31:0]    gr;
    logic [15:0]         iw;
    ouc_addr_t           addr;
    logic [7:0]          data;
    ouc_addr_t           rd_addr;
    logic [7:0]          rd_data;
    logic                req;
    logic                we;
    logic                done;
    logic                illegal;
    logic                taken;
    ouc_word_t           ea;
    ouc_word_t           operand;
  } ouc_reg_t;

  ouc_reg_t s;
  ouc_reg_t n;

  function automatic ouc_word_t ext_val(input ouc_word_t x,
                                        input logic [1:0] sz);
    unique case (sz)
      X_8:  ext_val = {24'h00_0000, x[7:0]};
      X_16: ext_val = {16'h0000, x[15:0]};
      X_24: ext_val = {8'h00, x[23:0]};
      default: ext_val = x;
    endcase
  endfunction

  // condition evaluation, flags are N Z V C from high to low.
  function automatic logic cond_met(input logic [3:0] cc,
                                    input logic [3:0] f);
    logic nv;
    nv = f[3] ^ f[1];
    unique case (cc[3:1])
      3'h0: cond_met = 1'b1;
      3'h1: cond_met = ~(f[0] | f[2]);
      3'h2: cond_met = ~f[0];
      3'h3: cond_met = ~f[2];
      3'h4: cond_met = ~f[1];
      3'h5: cond_met = ~f[3];
      3'h6: cond_met = ~nv;
      default: cond_met = ~(f[2] | nv);
    endcase
    if (cc[0]) begin
      cond_met = ~cond_met;
    end
  endfunction

  function automatic logic [7:0] mod_bit(input logic [2:0] k,
                                         input logic [7:0] b,
                                         input logic [2:0] bn,
                                         input logic c);
    logic [7:0] m;
    m = 8'h01 << bn;
    unique case (k)
      B_SET: mod_bit = b | m;
      B_CLR: mod_bit = b & ~m;
      B_NOT: mod_bit = b ^ m;
      B_ST:  mod_bit = c ? (b | m) : (b & ~m);
      B_IST: mod_bit = c ? (b & ~m) : (b | m);
      default: mod_bit = b;
    endcase
  endfunction

  // field split of the first instruction word
  logic [3:0] opf;
  logic [3:0] sub;
  logic [3:0] ra;
  logic [3:0] rb;
  logic [2:0] mode;
  logic [2:0] bkind;
  logic [2:0] bnum;
  logic [7:0] rbyte;
  logic [15:0] cnt;
  ouc_word_t xv;
  ouc_word_t disp;
  ouc_word_t dsum;
  assign opf   = instr_word_i[15:12];
  assign sub   = instr_word_i[11:8];
  assign ra    = instr_word_i[7:4];
  assign rb    = instr_word_i[3:0];
  assign mode  = sub[3:1];
  assign bkind = s.iw[11:9];
  assign xv    = ext_val(ext_i, ext_size_i);
  assign disp  = (ext_size_i == X_16) ? {{16{ext_i[15]}}, ext_i[15:0]}
                                      : {8'h00, ext_i[23:0]};
  assign dsum  = s.gr[ra[2:0]] + disp;
  // four-bit field picks high or low byte
  assign rbyte = ra[3] ? s.gr[ra[2:0]][7:0] : s.gr[ra[2:0]][15:8];
  // bit number from register or immediate
  assign bnum  = sub[0] ? s.gr[rb[2:0]][2:0] : rb[2:0];
  // count width follows the copy size
  assign cnt   = s.iw[8] ? s.gr[CNT_REG][15:0]
                         : {8'h00, s.gr[CNT_REG][7:0]};

  always_comb begin
    n = s;
    n.done = 1'b0;
    n.illegal = 1'b0;
    if (s.st == S_IDLE && reg_wr_i) begin
      n.gr[reg_idx_i] = reg_wdata_i;
    end
    unique case (s.st)
      S_IDLE: begin
        if (instr_valid_i) begin
          n.iw = instr_word_i;
          n.done = 1'b1;
          unique case (opf)
            OP_NOP: ;
            OP_EA: begin
              unique case (mode)
                M_IND:  n.ea = {8'h00, s.gr[ra[2:0]][23:0]};
                M_DISP: n.ea = {8'h00, dsum[23:0]};
                M_ABS:  n.ea = (ext_size_i == X_8) ?
                               {8'h00, SHORT_HI, ext_i[7:0]} : xv;
                M_IMM:  n.ea = xv;
                default: n.illegal = 1'b1;
              endcase
            end
            // ALU operands register or immediate only
            OP_ALU: begin
              if (mode == M_REG) begin
                n.operand = s.gr[ra[2:0]];
              end else if (mode == M_IMM) begin
                n.operand = xv;
              end else begin
                n.illegal = 1'b1;
              end
            end
            OP_XFER: n.illegal = (mode == M_PCR) || (mode == M_MIND);
            // byte, word half or full register
            OP_REG: begin
              unique case (sub[1:0])
                2'h0: n.operand = {24'h00_0000, rbyte};
                2'h1: n.operand = ra[3] ? {16'h0000, s.gr[ra[2:0]][31:16]}
                                        : {16'h0000, s.gr[ra[2:0]][15:0]};
                default: n.operand = s.gr[ra[2:0]];
              endcase
            end
            OP_BCC: n.taken = cond_met(sub, flags_i);
            OP_BIT_RD, OP_BIT_RI, OP_BIT_AB: begin
              // register bit number only for set/clear/invert/test
              if (sub[0] && !(sub[3:1] == B_SET || sub[3:1] == B_CLR ||
                              sub[3:1] == B_NOT || sub[3:1] == B_TST)) begin
                n.illegal = 1'b1;
              end else if (opf == OP_BIT_RD) begin
                n.operand = {31'h0, rbyte[bnum]};
                if (ra[3]) begin
                  n.gr[ra[2:0]][7:0] =
                    mod_bit(sub[3:1], rbyte, bnum, flags_i[0]);
                end else begin
                  n.gr[ra[2:0]][15:8] =
                    mod_bit(sub[3:1], rbyte, bnum, flags_i[0]);
                end
              end else begin
                n.done = 1'b0;
                n.iw[2:0] = bnum;
                n.addr = (opf == OP_BIT_AB) ? {SHORT_HI, ext_i[7:0]}
                                            : s.gr[ra[2:0]][23:0];
                n.req = 1'b1;
                n.we = 1'b0;
                n.st = S_BRD;
              end
            end
            OP_COPY: begin
              n.done = 1'b0;
              n.st = S_CCHK;
            end
            default: n.illegal = 1'b1;
          endcase
        end
      end
      S_BRD: begin
        if (mem_ack_i) begin
          // write-only direction register reads as ones
          n.rd_data = (s.addr == WO_DIR_ADDR) ? WO_READ : mem_rdata_i;
          n.rd_addr = s.addr;
          n.operand = {31'h0, n.rd_data[s.iw[2:0]]};
          // bit clear writes flag back after reading the byte
          n.data = mod_bit(bkind, n.rd_data, s.iw[2:0], flags_i[0]);
          if (bkind == B_TST) begin
            n.req = 1'b0;
            n.done = 1'b1;
            n.st = S_IDLE;
          end else begin
            n.we = 1'b1;
            n.st = S_BWR;
          end
        end
      end
      S_BWR, S_CWR: begin
        if (mem_ack_i) begin
          n.req = 1'b0;
          n.we = 1'b0;
          if (s.st == S_BWR) begin
            n.done = 1'b1;
            n.st = S_IDLE;
          end else begin
            n.gr[DST_REG] = s.gr[DST_REG] + 32'h1;
            if (s.iw[8]) begin
              n.gr[CNT_REG][15:0] = cnt - 16'h1;
            end else begin
              n.gr[CNT_REG][7:0] = cnt[7:0] - 8'h01;
            end
            n.st = S_CCHK;
          end
        end
      end
      S_CCHK: begin
        if (cnt == 16'h0000) begin
          n.done = 1'b1;
          n.st = S_IDLE;
        end else begin
          n.addr = s.gr[SRC_REG][23:0];
          n.req = 1'b1;
          n.we = 1'b0;
          n.st = S_CRD;
        end
      end
      S_CRD: begin
        if (mem_ack_i) begin
          n.data = mem_rdata_i;
          n.gr[SRC_REG] = s.gr[SRC_REG] + 32'h1;
          n.addr = s.gr[DST_REG][23:0];
          n.we = 1'b1;
          n.st = S_CWR;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s <= '0;
      s.st <= S_IDLE;
      s.gr <= {8{GR_RST}};
    end else begin
      s <= n;
    end
  end

  // One-hot state: bit 0 is the idle state, so ready comes from a flop.
  assign ready_o     = s.st[0];
  assign done_o      = s.done;
  assign illegal_o   = s.illegal;
  assign taken_o     = s.taken;
  assign ea_o        = s.ea;
  assign operand_o   = s.operand;
  assign mem_req_o   = s.req;
  assign mem_we_o    = s.we;
  assign mem_addr_o  = s.addr;
  assign mem_wdata_o = s.data;

  // Checks of the documented behaviour.
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);

  a_short_abs_ones: assert property (
    (s.st == S_IDLE && instr_valid_i && opf == OP_EA && mode == M_ABS &&
     ext_size_i == X_8) |=> ea_o[23:8] == SHORT_HI && done_o)
    else $error("short absolute upper bits not all ones");
  a_indirect_low24: assert property (
    (s.st == S_IDLE && instr_valid_i && opf == OP_EA && mode == M_IND)
    |=> ea_o == {8'h00, $past(s.gr[instr_word_i[6:4]][23:0])})
    else $error("indirect address not low 24 bits");
  a_rmw_same_addr: assert property (
    (s.st == S_BWR && mem_req_o) |-> mem_we_o && mem_addr_o == s.rd_addr)
    else $error("bit write address differs from read");
  a_rmw_one_bit: assert property (
    (s.st == S_BWR) |-> $countones(mem_wdata_o ^ s.rd_data) <= 1)
    else $error("bit write changed more than one bit");
  a_dir_reads_ones: assert property (
    (s.st == S_BRD && mem_ack_i && mem_addr_o == WO_DIR_ADDR)
    |=> s.rd_data == WO_READ)
    else $error("write-only register not read as ones");
  a_copy_count_dec: assert property (
    (s.st == S_CWR && mem_ack_i) |=> cnt == $past(cnt) - 16'h1)
    else $error("copy count not decremented");
  a_copy_zero_skip: assert property (
    (s.st == S_CCHK && cnt == 16'h0000) |=> done_o && ready_o && !mem_req_o)
    else $error("zero count copy did not finish at once");
  a_src_postinc: assert property (
    (s.st == S_CRD && mem_ack_i)
    |=> s.gr[SRC_REG] == $past(s.gr[SRC_REG]) + 32'h1 ##0 s.st == S_CWR)
    else $error("source pointer not advanced by one");
  a_alu_mode_check: assert property (
    (s.st == S_IDLE && instr_valid_i && opf == OP_ALU &&
     mode != M_REG && mode != M_IMM) |=> illegal_o)
    else $error("ALU accepted a memory mode");

  c_copy_full: cover property ((s.st == S_CWR && mem_ack_i) ##1
                               (s.st == S_CCHK && cnt == 16'h0000));
  c_bit_clear: cover property (s.st == S_BWR && bkind == B_CLR && mem_ack_i);
  c_branch_taken: cover property (done_o && taken_o);
endmodule // ouc_unit

/* File: ouc_mem.sv */
// Byte-wide memory and peripheral bus model facing the addressing unit.
`timescale 1ns/100ps
module ouc_mem (
  input  wire logic               core_clk_i,
  input  wire logic               reset_n_i,
  input  wire logic               mem_req_i,
  input  wire logic               mem_we_i,
  input  wire ouc_pkg::ouc_addr_t mem_addr_i,
  input  wire logic [7:0]         mem_wdata_i,
  input  wire logic [1:0]         dly_i,
  output logic [7:0]              mem_rdata_o,
  output logic                    mem_ack_o
);
  import ouc_pkg::*;
  logic [7:0] mem [0:511];
  logic [1:0] wait_cnt;
  logic [7:0] last;
  // Stalls dly_i cycles before answering, so zero answers at once.
  assign mem_ack_o = mem_req_i && (wait_cnt == dly_i);
  // Outside an answer the lines show the inverse of the last byte.
  always_comb begin
    if (!mem_ack_o || mem_we_i)
      mem_rdata_o = ~last;
    else if (mem_addr_i == WO_DIR_ADDR)
      mem_rdata_o = WO_READ;
    else
      mem_rdata_o = mem[mem_addr_i[8:0]];
  end
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wait_cnt <= 2'h0;
      last <= 8'h0;
    end else begin
      wait_cnt <= (mem_req_i && !mem_ack_o) ? wait_cnt + 2'h1 : 2'h0;
      if (mem_ack_o)
        last <= mem_we_i ? mem_wdata_i : mem_rdata_o;
      if (mem_ack_o && mem_we_i)
        mem[mem_addr_i[8:0]] <= mem_wdata_i;
    end
  end
endmodule // ouc_mem

/* File: cpu_operand_addressing_unit_test.sv */
// Self-checking bench for the operand addressing unit.
`timescale 1ns/100ps
module cpu_operand_addressing_unit_test;
  import ouc_pkg::*;
  typedef struct packed {
    logic [15:0] w;
    ouc_word_t   x;
    logic [1:0]  xs;
    logic        ill;
    logic [1:0]  k;
    ouc_word_t   e;
  } ouc_row_t;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        valid = 1'b0;
  logic [15:0] word = 16'h0;
  ouc_word_t   ext = 32'h0;
  logic [1:0]  xs = 2'h0;
  logic [3:0]  flags = 4'h0;
  logic        reg_wr = 1'b0;
  logic [2:0]  reg_idx = 3'h0;
  ouc_word_t   reg_wdata = 32'h0;
  logic [1:0]  dly = 2'h1;
  logic [7:0]  rdata, wdata, wr_d;
  logic        ack, ready, done, illegal, taken, req, we, ill_seen, rb;
  ouc_word_t   ea, operand;
  ouc_addr_t   addr, rd_a, wr_a;
  logic [2:0]  k, bn;
  int          rd_cnt = 0, wr_cnt = 0, error_cnt = 0, num_checks = 0;
  int          r0, w0;
  ouc_row_t    rows [24] = '{
    '{16'h1210, 32'h0, X_8, 1'b0, 2'h1, 32'h0034_5678},
    '{16'h1410, 32'h0000_8000, X_16, 1'b0, 2'h1, 32'h0033_d678},
    '{16'h1410, 32'h0010_0000, X_24, 1'b0, 2'h1, 32'h0044_5678},
    '{16'h1800, 32'h00ab_cdef, X_24, 1'b0, 2'h1, 32'h00ab_cdef},
    '{16'h1610, 32'h0, X_8, 1'b1, 2'h0, 32'h0},
    '{16'h2010, 32'h0, X_8, 1'b0, 2'h2, 32'h1234_5678},
    '{16'h2a00, 32'hcafe_0001, X_32, 1'b0, 2'h2, 32'hcafe_0001},
    '{16'h2210, 32'h0, X_8, 1'b1, 2'h0, 32'h0},
    '{16'h3c00, 32'h0, X_8, 1'b1, 2'h0, 32'h0},
    '{16'h3e00, 32'h0, X_8, 1'b1, 2'h0, 32'h0},
    '{16'h3210, 32'h0, X_8, 1'b0, 2'h0, 32'h0},
    '{16'h4090, 32'h0, X_8, 1'b0, 2'h2, 32'h78},
    '{16'h4010, 32'h0, X_8, 1'b0, 2'h2, 32'h56},
    '{16'h4190, 32'h0, X_8, 1'b0, 2'h2, 32'h1234},
    '{16'h4110, 32'h0, X_8, 1'b0, 2'h2, 32'h5678},
    '{16'h4210, 32'h0, X_8, 1'b0, 2'h2, 32'h1234_5678},
    '{16'h6710, 32'h0, X_8, 1'b1, 2'h0, 32'h0},
    '{16'hf000, 32'h0, X_8, 1'b1, 2'h0, 32'h0},
    '{16'h0000, 32'h0, X_8, 1'b0, 2'h0, 32'h0},
    '{16'h6a93, 32'h0, X_8, 1'b0, 2'h2, 32'h1},
    '{16'h6490, 32'h0, X_8, 1'b0, 2'h2, 32'h0},
    '{16'h4090, 32'h0, X_8, 1'b0, 2'h2, 32'h79},
    '{16'h1800, 32'h20, X_8, 1'b0, 2'h1, 32'h00ff_ff20},
    '{16'h1a00, 32'hcafe_0081, X_16, 1'b0, 2'h1, 32'h0000_0081}};

  ouc_unit u_ouc_unit (.core_clk_i(clk), .reset_n_i(reset_n),
    .instr_valid_i(valid), .instr_word_i(word), .ext_i(ext),
    .ext_size_i(xs), .flags_i(flags), .reg_wr_i(reg_wr),
    .reg_idx_i(reg_idx), .reg_wdata_i(reg_wdata), .mem_rdata_i(rdata),
    .mem_ack_i(ack), .ready_o(ready), .done_o(done), .illegal_o(illegal),
    .taken_o(taken), .ea_o(ea), .operand_o(operand), .mem_req_o(req),
    .mem_we_o(we), .mem_addr_o(addr), .mem_wdata_o(wdata));
  ouc_mem u_ouc_mem (.core_clk_i(clk), .reset_n_i(reset_n),
    .mem_req_i(req), .mem_we_i(we), .mem_addr_i(addr),
    .mem_wdata_i(wdata), .dly_i(dly), .mem_rdata_o(rdata),
    .mem_ack_o(ack));

  always #20 clk = ~clk;
  always @(posedge clk) begin
    if (req && ack && we) begin
      wr_cnt++;
      wr_a = addr;
      wr_d = wdata;
    end else if (req && ack) begin
      rd_cnt++;
      rd_a = addr;
    end
  end

  task check(input string name, input logic [31:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask
  task test_done;
    $display("checks %0d, errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task set_reg(input logic [2:0] i, input ouc_word_t v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_idx <= i;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task run(input logic [15:0] w, ouc_word_t x, logic [1:0] s, logic [3:0] f);
    int n;
    @(posedge clk);
    valid <= 1'b1;
    word <= w;
    ext <= x;
    xs <= s;
    flags <= f;
    @(posedge clk);
    valid <= 1'b0;
    #1;
    n = 0;
    while (done !== 1'b1 && n < 2000) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("done", 32'(n < 2000), 32'h1);
    ill_seen = illegal;
  endtask
  function automatic logic cond(input logic [3:0] c, f);
    logic r;
    case (c[3:1])
      3'h0: r = 1'b1;
      3'h1: r = ~(f[0] | f[2]);
      3'h2: r = ~f[0];
      3'h3: r = ~f[2];
      3'h4: r = ~f[1];
      3'h5: r = ~f[3];
      3'h6: r = ~(f[3] ^ f[1]);
      default: r = ~(f[2] | (f[3] ^ f[1]));
    endcase
    return c[0] ? ~r : r;
  endfunction
  function automatic logic [7:0] bitop(input logic [2:0] o, n);
    logic [7:0] r;
    r = 8'h5a;
    case (o)
      B_SET: r[n] = 1'b1;
      B_CLR: r[n] = 1'b0;
      B_NOT: r[n] = ~r[n];
      B_ST: r[n] = 1'b1;
      B_IST: r[n] = 1'b0;
      default: r = 8'h5a;
    endcase
    return r;
  endfunction
  task copy(input logic wm, input ouc_word_t c, input int n);
    set_reg(CNT_REG, c);
    set_reg(SRC_REG, 32'h0);
    set_reg(DST_REG, 32'h100);
    for (int i = 0; i < 256; i++) begin
      u_ouc_mem.mem[i] = i[7:0] ^ 8'h3c;
      u_ouc_mem.mem[256 + i] = 8'h0;
    end
    r0 = rd_cnt;
    run({OP_COPY, 3'h0, wm, 8'h0}, 32'h0, X_8, 4'h0);
    check("copy reads", 32'(rd_cnt - r0), 32'(n));
    for (int i = 0; i < n; i++)
      check("copy byte", u_ouc_mem.mem[256 + i], i[7:0] ^ 8'h3c);
    run(16'h4240, 32'h0, X_8, 4'h0);
    check("count", operand, wm ? {c[31:16], 16'h0} : {c[31:8], 8'h0});
    run(16'h4250, 32'h0, X_8, 4'h0);
    check("source", operand, 32'(n));
    run(16'h4260, 32'h0, X_8, 4'h0);
    check("dest", operand, 32'h100 + 32'(n));
  endtask

  initial begin
    #2_000_000;
    error_cnt++;
    $display("unexpected watchdog: expected finish, seen timeout");
    test_done();
  end
  initial begin
    // Reset starts low with no falling edge, so the unit clears at the
    // first clock edge; look only after it.
    @(posedge clk);
    #1;
    check("reset ready", ready, 32'h1);
    check("reset req", req, 32'h0);
    check("reset ea", ea, 32'h0);
    @(posedge clk);
    reset_n <= 1'b1;
    set_reg(3'h1, 32'h1234_5678);
    foreach (rows[i]) begin
      run(rows[i].w, rows[i].x, rows[i].xs, 4'h0);
      check("illegal", ill_seen, rows[i].ill);
      if (rows[i].k == 2'h1)
        check("ea", ea, rows[i].e);
      if (rows[i].k == 2'h2)
        check("operand", operand, rows[i].e);
    end
    for (int c = 0; c < 16; c++)
      for (int f = 0; f < 16; f++) begin
        run({OP_BCC, c[3:0], 8'h0}, 32'h0, X_8, f[3:0]);
        check("taken", taken, cond(c[3:0], f[3:0]));
      end
    set_reg(3'h2, 32'hff00_0010);
    set_reg(3'h3, 32'h0000_000e);
    for (int i = 0; i < 8; i++) begin
      k = i < 6 ? i[2:0] : (i == 6 ? B_CLR : B_TST);
      rb = i >= 6;
      bn = rb ? 3'h6 : i[2:0] + 3'h2;
      u_ouc_mem.mem[9'h10] = 8'h5a;
      r0 = rd_cnt;
      w0 = wr_cnt;
      run({OP_BIT_RI, k, rb, 4'h2, rb ? 4'h3 : {1'b0, bn}}, 32'h0, X_8, 4'h1);
      check("bit reads", 32'(rd_cnt - r0), 32'h1);
      check("bit writes", 32'(wr_cnt - w0), 32'(k != B_TST));
      check("bit addr", rd_a, 24'h10);
      if (k != B_TST)
        check("bit write addr", wr_a, 24'h10);
      check("bit byte", u_ouc_mem.mem[9'h10], bitop(k, bn));
      if (k == B_TST)
        check("bit test", operand, 32'((8'h5a >> bn) & 8'h01));
    end
    r0 = rd_cnt;
    run(16'h8200, 32'h20, X_8, 4'h0);
    check("short addr", wr_a, 24'hffff20);
    check("direction byte", wr_d, 8'hfe);
    u_ouc_mem.mem[9'h130] = 8'h81;
    run(16'h8207, 32'h30, X_8, 4'h0);
    check("flag byte", u_ouc_mem.mem[9'h130], 8'h01);
    check("flag reads", 32'(rd_cnt - r0), 32'h2);
    copy(1'b0, 32'h3, 3);
    copy(1'b0, 32'h100, 0);
    @(posedge clk);
    dly <= 2'h0;
    copy(1'b1, 32'h100, 256);
    copy(1'b1, 32'h0, 0);
    // Reset in mid-run must clear outputs and the register file again.
    @(posedge clk);
    reset_n <= 1'b0;
    @(posedge clk);
    #1;
    check("mid reset ready", ready, 32'h1);
    check("mid reset req", req, 32'h0);
    check("mid reset ea", ea, 32'h0);
    check("mid reset operand", operand, 32'h0);
    @(posedge clk);
    reset_n <= 1'b1;
    run(16'h4260, 32'h0, X_8, 4'h0);
    check("mid reset dest", operand, GR_RST);
    test_done();
  end
endmodule // cpu_operand_addressing_unit_test
